// file: rtl/ogs_pkg.sv
// Purpose: Shared constants and types of the output gearbox serializer
// Assumes: One core clock; serial bits leave as two half-cycle slots per clock
// Notes: Mode codes arrive on the mode pins and are synchronised inside the top
package ogs_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int OGS_DATA_W = 8;
  localparam int OGS_LANE_W = 4;
  localparam int OGS_CNT_W = 3;
  localparam int OGS_FIFO_DEPTH = 16;
  localparam int OGS_MODE_W = 2;

  // ****************************************
  // Word layout
  // ****************************************
  localparam int OGS_LANE_A_LSB = 0;
  localparam int OGS_LANE_C_LSB = 4;

  // ****************************************
  // Slots per word, two serial bits per slot except 7:1
  // ****************************************
  localparam logic [OGS_CNT_W-1:0] OGS_SLOTS_7TO1 = 3'h7;
  localparam logic [OGS_CNT_W-1:0] OGS_SLOTS_8TO1 = 3'h4;
  localparam logic [OGS_CNT_W-1:0] OGS_SLOTS_4TO1 = 3'h2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [OGS_DATA_W-1:0] OGS_WORD_RST = 8'h00;
  localparam logic [OGS_CNT_W-1:0] OGS_CNT_RST = 3'h0;
  localparam logic [1:0] OGS_PAIR_RST = 2'h0;

  // ****************************************
  // Mode codes on the mode pins
  // ****************************************
  typedef enum logic [OGS_MODE_W-1:0] {
    OGS_SEVEN_TO_ONE,
    OGS_EIGHT_TO_ONE_MODE,
    OGS_FOUR_TO_ONE_MODE,
    OGS_MODE_SPARE
  } ogs_mode_t;

endpackage : ogs_pkg

// file: rtl/ogs_fifo.sv
// Purpose: Word FIFO in front of the gearbox pipeline
// Assumes: Single clock, synchronous active-high reset
// Notes: Read data is the flop array entry at the read pointer
`timescale 1ns/100ps
module ogs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // ****************************************
  // Flags and pointers
  // ****************************************
  always_comb begin
    empty = (wr_ptr == rd_ptr);
    full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    o_in_ready = !full;
    o_out_valid = !empty;
    o_out_data = mem[rd_ptr[AW-1:0]];
    push = i_in_valid && !full;
    pop = i_out_ready && !empty;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

endmodule : ogs_fifo

// file: rtl/ogs_gearbox.sv
// Purpose: Output gearbox, parallel core words to serial bits on one or two lanes
// Assumes: Serial bits leave as a first and second half-cycle slot per clock, with one bit repeated in both slots in 7:1
// Notes: Mode pins are synchronised; each word keeps the mode it was captured with
//   Words queue in a 16-deep FIFO ahead of the three stages
//   The shifter reloads on its last slot, so back-to-back words leave with no gap
//   A mode change takes effect for the first word captured after the sync delay
`timescale 1ns/100ps
module ogs_gearbox (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic [ogs_pkg::OGS_MODE_W-1:0] I_MODE,
  input wire logic I_VALID,
  output logic O_READY,
  input wire logic [ogs_pkg::OGS_DATA_W-1:0] I_DATA,
  output logic [1:0] O_Q_LANE_A,
  output logic [1:0] O_Q_LANE_C,
  output logic O_WORD_START,
  output logic O_BUSY
);
  import ogs_pkg::*;

  // ****************************************
  // Mode synchroniser
  // ****************************************
  logic [OGS_MODE_W-1:0] mode_meta;
  logic [OGS_MODE_W-1:0] mode_sync;
  logic [OGS_MODE_W-1:0] next_mode_meta;
  logic [OGS_MODE_W-1:0] next_mode_sync;

  always_comb begin
    next_mode_meta = I_MODE;
    next_mode_sync = mode_meta;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      mode_meta <= '0;
      mode_sync <= '0;
    end else begin
      mode_meta <= next_mode_meta;
      mode_sync <= next_mode_sync;
    end
  end

  function automatic ogs_mode_t decode_mode(input logic [OGS_MODE_W-1:0] code);
    ogs_mode_t m;
    unique case (code)
      2'h0: m = OGS_SEVEN_TO_ONE;
      2'h2: m = OGS_FOUR_TO_ONE_MODE;
      default: m = OGS_EIGHT_TO_ONE_MODE;
    endcase
    return m;
  endfunction : decode_mode

  function automatic logic [OGS_CNT_W-1:0] slots_of(input ogs_mode_t m);
    logic [OGS_CNT_W-1:0] n;
    unique case (m)
      OGS_SEVEN_TO_ONE: n = OGS_SLOTS_7TO1;
      OGS_FOUR_TO_ONE_MODE: n = OGS_SLOTS_4TO1;
      default: n = OGS_SLOTS_8TO1;
    endcase
    return n;
  endfunction : slots_of

  // ****************************************
  // Word FIFO
  // ****************************************
  logic fifo_valid;
  logic fifo_ready;
  logic [OGS_DATA_W-1:0] fifo_data;

  ogs_fifo #(
    .WIDTH(OGS_DATA_W),
    .DEPTH(OGS_FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_in_valid(I_VALID),
    .o_in_ready(O_READY),
    .i_in_data(I_DATA),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_ready),
    .o_out_data(fifo_data)
  );

  // ****************************************
  // Pipeline state
  // ****************************************
  logic s1_valid;
  logic [OGS_DATA_W-1:0] s1_word;
  ogs_mode_t s1_mode;
  logic s2_valid;
  logic [OGS_DATA_W-1:0] s2_word;
  ogs_mode_t s2_mode;
  logic [OGS_DATA_W-1:0] sh;
  logic [OGS_CNT_W-1:0] cnt;
  ogs_mode_t s3_mode;
  logic first_slot;

  // ****************************************
  // Next values
  // ****************************************
  logic next_s1_valid;
  logic [OGS_DATA_W-1:0] next_s1_word;
  ogs_mode_t next_s1_mode;
  logic next_s2_valid;
  logic [OGS_DATA_W-1:0] next_s2_word;
  ogs_mode_t next_s2_mode;
  logic [OGS_DATA_W-1:0] next_sh;
  logic [OGS_CNT_W-1:0] next_cnt;
  ogs_mode_t next_s3_mode;
  logic next_first_slot;
  logic [1:0] next_q_a;
  logic [1:0] next_q_c;
  logic next_word_start;

  // ****************************************
  // Stage strobes
  // ****************************************
  logic s3_take;
  logic s2_take;
  logic last_slot;

  // ****************************************
  // Lane pair picker
  // ****************************************
  function automatic logic [1:0] pair_at(input logic [OGS_DATA_W-1:0] w, input int lsb);
    return w[lsb +: 2];
  endfunction : pair_at

  // ****************************************
  // Stage handshakes
  // ****************************************
  always_comb begin
    last_slot = (cnt <= 3'h1);
    // Refill on the last slot so the next word follows without a gap
    s3_take = s2_valid && last_slot;
    s2_take = s1_valid && (!s2_valid || s3_take);
    fifo_ready = !s1_valid || s2_take;
  end

  // ****************************************
  // Stage one, capture from the FIFO
  // ****************************************
  always_comb begin
    next_s1_valid = s1_valid;
    next_s1_word = s1_word;
    next_s1_mode = s1_mode;
    if (fifo_ready) begin
      next_s1_valid = fifo_valid;
      if (fifo_valid) begin
        next_s1_word = fifo_data;
        next_s1_mode = decode_mode(mode_sync);
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      s1_valid <= 1'b0;
      s1_word <= OGS_WORD_RST;
      s1_mode <= OGS_SEVEN_TO_ONE;
    end else begin
      s1_valid <= next_s1_valid;
      s1_word <= next_s1_word;
      s1_mode <= next_s1_mode;
    end
  end

  // ****************************************
  // Stage two, hand over to the shifter side
  // ****************************************
  always_comb begin
    next_s2_valid = s2_valid;
    next_s2_word = s2_word;
    next_s2_mode = s2_mode;
    if (!s2_valid || s3_take) begin
      next_s2_valid = s1_valid;
      if (s1_valid) begin
        next_s2_word = s1_word;
        next_s2_mode = s1_mode;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      s2_valid <= 1'b0;
      s2_word <= OGS_WORD_RST;
      s2_mode <= OGS_SEVEN_TO_ONE;
    end else begin
      s2_valid <= next_s2_valid;
      s2_word <= next_s2_word;
      s2_mode <= next_s2_mode;
    end
  end

  // ****************************************
  // Stage three, shifter
  // ****************************************
  always_comb begin
    next_sh = sh;
    next_cnt = cnt;
    next_s3_mode = s3_mode;
    next_first_slot = first_slot;
    if (cnt != OGS_CNT_RST) begin
      next_first_slot = 1'b0;
      next_cnt = cnt - 3'h1;
      unique case (s3_mode)
        OGS_SEVEN_TO_ONE: begin
          next_sh = {1'b0, sh[OGS_DATA_W-1:1]};
        end
        OGS_FOUR_TO_ONE_MODE: begin
          next_sh = {2'h0, sh[OGS_LANE_C_LSB+OGS_LANE_W-1:OGS_LANE_C_LSB+2],
                     2'h0, sh[OGS_LANE_A_LSB+OGS_LANE_W-1:OGS_LANE_A_LSB+2]};
        end
        default: begin
          next_sh = {2'h0, sh[OGS_DATA_W-1:2]};
        end
      endcase
    end
    // The mode travels with the word, so a pin change never splits it
    if (s3_take) begin
      next_sh = s2_word;
      next_s3_mode = s2_mode;
      next_cnt = slots_of(s2_mode);
      next_first_slot = 1'b1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      sh <= OGS_WORD_RST;
      cnt <= OGS_CNT_RST;
      s3_mode <= OGS_SEVEN_TO_ONE;
      first_slot <= 1'b0;
    end else begin
      sh <= next_sh;
      cnt <= next_cnt;
      s3_mode <= next_s3_mode;
      first_slot <= next_first_slot;
    end
  end

  // ****************************************
  // Output registers
  // ****************************************
  always_comb begin
    next_q_a = OGS_PAIR_RST;
    next_q_c = OGS_PAIR_RST;
    next_word_start = 1'b0;
    if (cnt != OGS_CNT_RST) begin
      next_word_start = first_slot;
      unique case (s3_mode)
        OGS_SEVEN_TO_ONE: begin
          next_q_a = {sh[0], sh[0]};
        end
        OGS_FOUR_TO_ONE_MODE: begin
          next_q_a = pair_at(sh, OGS_LANE_A_LSB);
          next_q_c = pair_at(sh, OGS_LANE_C_LSB);
        end
        default: begin
          next_q_a = pair_at(sh, 0);
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_Q_LANE_A <= OGS_PAIR_RST;
      O_Q_LANE_C <= OGS_PAIR_RST;
      O_WORD_START <= 1'b0;
    end else begin
      O_Q_LANE_A <= next_q_a;
      O_Q_LANE_C <= next_q_c;
      O_WORD_START <= next_word_start;
    end
  end

  // ****************************************
  // Status
  // ****************************************
  always_comb begin
    O_BUSY = s1_valid || s2_valid || (cnt != OGS_CNT_RST) || fifo_valid;
  end

endmodule : ogs_gearbox

// file: sim/ogs_gearbox_properties.sv
// Purpose: Port assertions of the output gearbox
// Assumes: Bound to ogs_gearbox, one clock
// Notes: Latency counted from an idle pipeline
`timescale 1ns/100ps
module ogs_gearbox_properties (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic [ogs_pkg::OGS_MODE_W-1:0] I_MODE,
  input wire logic I_VALID,
  input wire logic O_READY,
  input wire logic [ogs_pkg::OGS_DATA_W-1:0] I_DATA,
  input wire logic [1:0] O_Q_LANE_A,
  input wire logic [1:0] O_Q_LANE_C,
  input wire logic O_WORD_START,
  input wire logic O_BUSY
);
  import ogs_pkg::*;
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SRST);
  // ****************
  // Assertions
  // ****************
  sequence s_first_slot;
    !O_WORD_START [*4] ##1 O_WORD_START;
  endsequence
  a_reset_clears: assert property (disable iff (1'b0) I_SRST |=> O_READY && !O_BUSY && !O_WORD_START
    && O_Q_LANE_A == 2'h0 && O_Q_LANE_C == 2'h0) else $error("not cleared by reset");
  a_start_latency: assert property (I_VALID && O_READY && !O_BUSY |=> s_first_slot)
    else $error("first slot latency wrong");
  a_start_single: assert property (O_WORD_START |=> !O_WORD_START) else $error("start too long");
  a_start_busy: assert property (O_WORD_START |-> O_BUSY && $past(O_BUSY, 4)) else $error("start idle");
  a_take_busy: assert property (I_VALID && O_READY |=> O_BUSY [*3]) else $error("busy late");
  a_ready_idle: assert property (!O_BUSY |-> O_READY) else $error("refused while idle");
  a_idle_quiet: assert property (!O_BUSY && !$past(O_BUSY) |-> O_Q_LANE_A == 2'h0 && O_Q_LANE_C == 2'h0)
    else $error("lanes not quiet");
  a_lane_c_mode: assert property (O_Q_LANE_C != 2'h0 |-> $past(I_MODE, 5) == OGS_FOUR_TO_ONE_MODE)
    else $error("lane c outside dual mode");
endmodule : ogs_gearbox_properties

// file: sim/ogs_core_src.sv
// Purpose: Core fabric model offering words
// Assumes: Words pushed off the rising edge
// Notes: Data toggles while nothing is offered
`timescale 1ns/100ps
module ogs_core_src (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic o_valid,
  output logic [ogs_pkg::OGS_DATA_W-1:0] o_data
);
  import ogs_pkg::*;
  logic [OGS_DATA_W-1:0] q[$];
  initial begin
    o_valid = 1'b0;
    o_data = OGS_WORD_RST;
  end
  task automatic push(input logic [OGS_DATA_W-1:0] w);
    q.push_back(w);
  endtask : push
  // ****************
  // Word offer
  // ****************
  always @(posedge i_clk) begin
    if (o_valid && i_ready) q.delete(0);
    o_valid <= q.size() > 0;
    o_data <= q.size() > 0 ? q[0] : ~o_data;
  end
endmodule : ogs_core_src

// file: sim/ogs_gearbox_bench.sv
// Purpose: Self-checking bench of the output gearbox
// Assumes: Core model feeds words, bench sets mode
// Notes: Table of words, then fill and reset by hand
`timescale 1ns/100ps
module output_gearbox_serializer_bench;
  import ogs_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] data;
    logic [2:0] n;
    logic [13:0] exp_a;
    logic [13:0] exp_c;
  } ogs_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] mode = 2'h1;
  logic valid, ready, start, busy;
  logic [7:0] data, w;
  logic [1:0] qa, qc;
  logic saw_full = 1'b0;
  int err_total = 0;
  int num_checks = 0;
  int waited;
  ogs_row_t rows [5] = '{'{2'h1, 8'hb4, OGS_SLOTS_8TO1, 14'h00b4, 14'h0},
    '{2'h3, 8'h5a, OGS_SLOTS_8TO1, 14'h005a, 14'h0}, '{2'h2, 8'hc9, OGS_SLOTS_4TO1, 14'h0009, 14'h000c},
    '{2'h0, 8'hd3, OGS_SLOTS_7TO1, 14'h330f, 14'h0}, '{2'h0, 8'h2c, OGS_SLOTS_7TO1, 14'h0cf0, 14'h0}};
  ogs_gearbox uut (.I_CORE_CLK(clk), .I_SRST(srst), .I_MODE(mode), .I_VALID(valid), .O_READY(ready),
    .I_DATA(data), .O_Q_LANE_A(qa), .O_Q_LANE_C(qc), .O_WORD_START(start), .O_BUSY(busy));
  ogs_core_src src (.i_clk(clk), .i_ready(ready), .o_valid(valid), .o_data(data));
  always #12.5 clk = ~clk;
  always @(negedge clk) if (ready === 1'b0 && srst === 1'b0) saw_full <= 1'b1;
  task automatic check(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, what);
    end
  endtask : check
  task automatic get_word(input logic [2:0] n, input logic [13:0] ea, input logic [13:0] ec);
    waited = 0;
    while (start !== 1'b1 && waited < 40) begin
      @(negedge clk);
      waited++;
    end
    check(waited < 40, "no word start");
    for (int k = 0; k < n; k++) begin
      check(qa === ea[2*k+:2] && qc === ec[2*k+:2], "slot data");
      @(negedge clk);
    end
  endtask : get_word
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    mode <= m;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : set_mode
  task automatic send_row(input ogs_row_t r);
    set_mode(r.mode);
    src.push(r.data);
    get_word(r.n, r.exp_a, r.exp_c);
    check(qa === 2'h0 && qc === 2'h0, "not idle after word");
  endtask : send_row
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // ****************
  // Stimulus
  // ****************
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check(ready === 1'b1 && busy === 1'b0 && qa === 2'h0, "state after reset");
    foreach (rows[i]) send_row(rows[i]);
    set_mode(2'h2);
    for (int i = 0; i < 40; i++) src.push(8'(i * 37));
    for (int i = 0; i < 40; i++) begin
      w = 8'(i * 37);
      get_word(OGS_SLOTS_4TO1, {10'h0, w[3:0]}, {10'h0, w[7:4]});
      if (i > 0) check(waited == 0, "gap in stream");
    end
    @(negedge clk);
    check(saw_full === 1'b1 && busy === 1'b0 && ready === 1'b1, "fill or drain");
    set_mode(2'h0);
    src.push(8'hff);
    repeat (8) @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    check(qa === 2'h0 && ready === 1'b1 && busy === 1'b0, "reset mid word");
    send_row(rows[3]);
    complete_run();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule : output_gearbox_serializer_bench
bind ogs_gearbox ogs_gearbox_properties chk (.I_CORE_CLK(I_CORE_CLK), .I_SRST(I_SRST), .I_MODE(I_MODE),
  .I_VALID(I_VALID), .O_READY(O_READY), .I_DATA(I_DATA), .O_Q_LANE_A(O_Q_LANE_A), .O_Q_LANE_C(O_Q_LANE_C),
  .O_WORD_START(O_WORD_START), .O_BUSY(O_BUSY));
